// file: rtl/hpfs_defs.svh
// Constants for the host port pin function select block.
// Assumes inclusion by bare name from every design file but the package.
//
// Contract
// - Serial mode: select pin is active-low chip select.
// - Two-wire mode: select pin is low address strap.
// - Second pin: serial data in, else high strap.
// - Serial output three-state in four-wire mode only.
// - Data pin open-drain in two-wire mode only.
// - Interrupt open-drain active-low, enabled sources only.
// - Interrupt sources: pins, errors, data, space, modem.
// - Modem control bit 1 drives request-to-send low.
// - Request-to-send high after any reset.
// - Datapath steers request-to-send only with auto enable.
// - Pins 4 to 7: general I/O or modem.
// - I/O control bit 1 picks modem pin function.
`ifndef HPFS_DEFS_SVH
`define HPFS_DEFS_SVH

// ****************************************
// Register bit positions
// ****************************************
`define HPFS_MCR_DTR_BIT      0
`define HPFS_MCR_RTS_BIT      1
`define HPFS_EFR_AUTO_RTS_BIT 6
`define HPFS_IOC_MODEM_BIT    1
`define HPFS_IER_RX_DATA_BIT  0
`define HPFS_IER_TX_SPACE_BIT 1
`define HPFS_IER_RX_ERR_BIT   2
`define HPFS_IER_MODEM_BIT    3
`define HPFS_IER_PIN_CHG_BIT  4

// ****************************************
// Reset values
// ****************************************
`define HPFS_RTS_N_RST        1'b1
`define HPFS_ADDR_STRAP_RST   2'h0
`define HPFS_PIN_OUT_RST      1'b0
`define HPFS_PIN_OE_N_RST     1'b1

`endif

// file: rtl/hpfs_pkg.sv
// Types shared by the host port pin function select block.
// Assumes nothing beyond a SystemVerilog compiler.
package hpfs_pkg;

   // ****************************************
   // Strap capture states
   // ****************************************
   typedef enum logic [1:0] {
      HPFS_ST_WAIT = 2'b01,
      HPFS_ST_RUN  = 2'b10
   } hpfs_strap_st_t;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic       is_i2c;
      logic [1:0] addr;
   } hpfs_strap_t;

   typedef struct packed {
      logic pin_change;
      logic modem_status;
      logic rx_error;
      logic tx_space;
      logic rx_data;
   } hpfs_irq_src_t;

endpackage : hpfs_pkg

// file: rtl/hpfs_pin_cell.sv
// Registered driver for one shared pin: value and active-low enable.
// Assumes the pad resolves the wire level from the enable.
`timescale 1ns/1ns
`include "hpfs_defs.svh"
module hpfs_pin_cell (
   // Clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   // Drive request
   input  wire logic drive_en,
   input  wire logic drive_val,
   // Pin side
   output logic      pin_o,
   output logic      pin_oe_n
);
   logic pin_d;
   logic oe_n_d;
   logic pin_q;
   logic oe_n_q;

   always_comb begin
      pin_d  = drive_en ? drive_val : `HPFS_PIN_OUT_RST;
      oe_n_d = ~drive_en;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         pin_q  <= `HPFS_PIN_OUT_RST;
         oe_n_q <= `HPFS_PIN_OE_N_RST;
      end else begin
         pin_q  <= pin_d;
         oe_n_q <= oe_n_d;
      end
   end

   assign pin_o    = pin_q;
   assign pin_oe_n = oe_n_q;
endmodule : hpfs_pin_cell

// file: rtl/hpfs_irq.sv
// Interrupt combiner: gates source levels with the enable register.
// Assumes sources are levels held by the core until serviced.
`timescale 1ns/1ns
`include "hpfs_defs.svh"
module hpfs_irq (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  nrst,
   // Sources and enables
   input  wire hpfs_pkg::hpfs_irq_src_t src,
   input  wire logic [7:0]            enable,
   // Result
   output logic                       pending
);
   logic pending_d;
   logic pending_q;

   always_comb begin
      pending_d = (src.rx_data      & enable[`HPFS_IER_RX_DATA_BIT])  |
                  (src.tx_space     & enable[`HPFS_IER_TX_SPACE_BIT]) |
                  (src.rx_error     & enable[`HPFS_IER_RX_ERR_BIT])   |
                  (src.modem_status & enable[`HPFS_IER_MODEM_BIT])    |
                  (src.pin_change   & enable[`HPFS_IER_PIN_CHG_BIT]);
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         pending_q <= 1'b0;
      end else begin
         pending_q <= pending_d;
      end
   end

   assign pending = pending_q;
endmodule : hpfs_irq

// file: rtl/hpfs_top.sv
// Pin function select for the serial-bus host port of a UART bridge.
// Assumes all pins are synchronous to CLK and the pads resolve the
// two-way pins from the active-low enables given here.
`timescale 1ns/1ns
`include "hpfs_defs.svh"
module hpfs_top #(
   parameter int PROG_PINS = 4
) (
   // Clock and reset
   input  wire logic                  CLK,
   input  wire logic                  NRST,
   // Straps and shared inputs
   input  wire logic                  BUS_SEL_I2C,
   input  wire logic                  SELECT_OR_ADDR_STRAP_LOW,
   input  wire logic                  SERIAL_IN_OR_ADDR_STRAP_HIGH,
   // Serial output pin
   output logic                       SO_O,
   output logic                       SO_OE_N,
   // Two-wire data pin
   input  wire logic                  SDA_I,
   output logic                       SDA_O,
   output logic                       SDA_OE_N,
   // Interrupt pin, open drain
   output logic                       IRQ_N_O,
   output logic                       IRQ_N_OE_N,
   // Request to send pin
   output logic                       RTS_N,
   // Programmable pins 4 to 7
   input  wire logic [PROG_PINS-1:0]  PROG_PIN_I,
   output logic      [PROG_PINS-1:0]  PROG_PIN_O,
   output logic      [PROG_PINS-1:0]  PROG_PIN_OE_N,
   // Core: strap results
   output hpfs_pkg::hpfs_strap_t      STRAP,
   output logic                       STRAP_VALID,
   // Core: serial bus side
   output logic                       SPI_CS_N,
   output logic                       SPI_DATA_IN,
   input  wire logic                  CORE_SO_DATA,
   input  wire logic                  CORE_SO_EN,
   input  wire logic                  CORE_SDA_PULL_LOW,
   output logic                       CORE_SDA_IN,
   // Core: registers
   input  wire logic [7:0]            INTERRUPT_ENABLE_REG,
   input  wire logic [7:0]            MODEM_CONTROL_REG,
   input  wire logic [7:0]            ENHANCED_FEATURE_REG,
   input  wire logic [7:0]            IO_CONTROL_REG,
   // Core: interrupt sources and status
   input  wire hpfs_pkg::hpfs_irq_src_t IRQ_SRC,
   output logic                       IRQ_PENDING,
   // Core: flow control
   input  wire logic                  AUTO_RTS_READY,
   output logic                       AUTO_RTS_EN,
   // Core: programmable pins
   input  wire logic [PROG_PINS-1:0]  GPIO_OUT,
   input  wire logic [PROG_PINS-1:0]  GPIO_DIR_OUT,
   output logic      [PROG_PINS-1:0]  GPIO_IN,
   output logic                       MODEM_PINS_ACTIVE,
   output logic                       MODEM_DSR_N,
   output logic                       MODEM_CD_N,
   output logic                       MODEM_RI_N
);

   // ****************************************
   // Strap capture
   // ****************************************
   // Straps are sampled on the first edge after reset release, so a
   // reset never loads a port value directly.
   hpfs_pkg::hpfs_strap_st_t st_d;
   hpfs_pkg::hpfs_strap_st_t st_q;
   hpfs_pkg::hpfs_strap_t    strap_d;
   hpfs_pkg::hpfs_strap_t    strap_q;
   logic                     run;

   always_comb begin
      st_d    = st_q;
      strap_d = strap_q;
      case (st_q)
         hpfs_pkg::HPFS_ST_WAIT: begin
            strap_d.is_i2c = BUS_SEL_I2C;
            if (BUS_SEL_I2C) begin
               strap_d.addr = {SERIAL_IN_OR_ADDR_STRAP_HIGH,
                               SELECT_OR_ADDR_STRAP_LOW};
            end else begin
               strap_d.addr = `HPFS_ADDR_STRAP_RST;
            end
            st_d = hpfs_pkg::HPFS_ST_RUN;
         end
         hpfs_pkg::HPFS_ST_RUN: begin
            st_d = hpfs_pkg::HPFS_ST_RUN;
         end
         default: begin
            st_d = hpfs_pkg::HPFS_ST_WAIT;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         st_q           <= hpfs_pkg::HPFS_ST_WAIT;
         strap_q.is_i2c <= 1'b0;
         strap_q.addr   <= `HPFS_ADDR_STRAP_RST;
      end else begin
         st_q    <= st_d;
         strap_q <= strap_d;
      end
   end

   assign run         = (st_q == hpfs_pkg::HPFS_ST_RUN);
   assign STRAP       = strap_q;
   assign STRAP_VALID = run;

   // ****************************************
   // Serial bus inputs toward the core
   // ****************************************
   logic spi_mode;
   logic cs_n_d;
   logic cs_n_q;
   logic si_d;
   logic si_q;
   logic sda_in_d;
   logic sda_in_q;

   assign spi_mode = run & ~strap_q.is_i2c;

   always_comb begin
      // Chip select held inactive outside four-wire mode
      cs_n_d   = spi_mode ? SELECT_OR_ADDR_STRAP_LOW : 1'b1;
      si_d     = spi_mode & SERIAL_IN_OR_ADDR_STRAP_HIGH;
      // Data pin ignored in four-wire mode, where it is tied low
      sda_in_d = (run & strap_q.is_i2c) ? SDA_I : 1'b1;
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         cs_n_q   <= 1'b1;
         si_q     <= 1'b0;
         sda_in_q <= 1'b1;
      end else begin
         cs_n_q   <= cs_n_d;
         si_q     <= si_d;
         sda_in_q <= sda_in_d;
      end
   end

   assign SPI_CS_N    = cs_n_q;
   assign SPI_DATA_IN = si_q;
   assign CORE_SDA_IN = sda_in_q;

   // ****************************************
   // Serial output and data pin drivers
   // ****************************************
   logic so_drive;
   logic sda_drive;

   // Released whenever chip select is high so other slaves can share
   assign so_drive  = spi_mode & ~SELECT_OR_ADDR_STRAP_LOW & CORE_SO_EN;
   // Open drain: only ever pulls low, never drives high
   assign sda_drive = run & strap_q.is_i2c & CORE_SDA_PULL_LOW;

   hpfs_pin_cell u_so (
      .clk       (CLK),
      .nrst      (NRST),
      .drive_en  (so_drive),
      .drive_val (CORE_SO_DATA),
      .pin_o     (SO_O),
      .pin_oe_n  (SO_OE_N)
   );

   hpfs_pin_cell u_sda (
      .clk       (CLK),
      .nrst      (NRST),
      .drive_en  (sda_drive),
      .drive_val (1'b0),
      .pin_o     (SDA_O),
      .pin_oe_n  (SDA_OE_N)
   );

   // ****************************************
   // Interrupt output
   // ****************************************
   logic irq_pend;

   // Two flops from source to pad: combiner, then pad driver. The
   // core must hold a source until serviced; no event is latched here.
   hpfs_irq u_irq (
      .clk     (CLK),
      .nrst    (NRST),
      .src     (IRQ_SRC),
      .enable  (INTERRUPT_ENABLE_REG),
      .pending (irq_pend)
   );

   hpfs_pin_cell u_irq_pin (
      .clk       (CLK),
      .nrst      (NRST),
      .drive_en  (irq_pend),
      .drive_val (1'b0),
      .pin_o     (IRQ_N_O),
      .pin_oe_n  (IRQ_N_OE_N)
   );

   assign IRQ_PENDING = irq_pend;

   // ****************************************
   // Request to send
   // ****************************************
   logic rts_n_d;
   logic rts_n_q;
   logic auto_rts_d;
   logic auto_rts_q;

   // Auto mode hands the pin to the receive fill level; the manual
   // bit is ignored until auto mode is switched off again.
   always_comb begin
      auto_rts_d = ENHANCED_FEATURE_REG[`HPFS_EFR_AUTO_RTS_BIT];
      if (auto_rts_d) begin
         rts_n_d = ~AUTO_RTS_READY;
      end else begin
         rts_n_d = ~MODEM_CONTROL_REG[`HPFS_MCR_RTS_BIT];
      end
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         rts_n_q    <= `HPFS_RTS_N_RST;
         auto_rts_q <= 1'b0;
      end else begin
         rts_n_q    <= rts_n_d;
         auto_rts_q <= auto_rts_d;
      end
   end

   assign RTS_N       = rts_n_q;
   assign AUTO_RTS_EN = auto_rts_q;

   // ****************************************
   // Programmable pins 4 to 7
   // ****************************************
   // Pin index 1 carries terminal-ready out; the others are modem inputs.
   localparam int DTR_IDX = 1;
   localparam int DSR_IDX = 0;
   localparam int CD_IDX  = 2;
   localparam int RI_IDX  = 3;

   logic                 modem_sel;
   logic [PROG_PINS-1:0] pin_drive;
   logic [PROG_PINS-1:0] pin_val;
   logic [PROG_PINS-1:0] gpio_in_d;
   logic [PROG_PINS-1:0] gpio_in_q;
   logic [2:0]           modem_in_d;
   logic [2:0]           modem_in_q;
   logic                 modem_act_d;
   logic                 modem_act_q;

   assign modem_sel = IO_CONTROL_REG[`HPFS_IOC_MODEM_BIT];

   always_comb begin
      // Flag is registered once, so it changes on the same edge as the pin drivers
      modem_act_d = modem_sel;
      if (modem_sel) begin
         pin_drive          = '0;
         pin_val            = '0;
         pin_drive[DTR_IDX] = 1'b1;
         pin_val[DTR_IDX]   = ~MODEM_CONTROL_REG[`HPFS_MCR_DTR_BIT];
         gpio_in_d          = '0;
         modem_in_d         = {PROG_PIN_I[RI_IDX], PROG_PIN_I[CD_IDX],
                               PROG_PIN_I[DSR_IDX]};
      end else begin
         pin_drive  = GPIO_DIR_OUT;
         pin_val    = GPIO_OUT;
         gpio_in_d  = PROG_PIN_I;
         // Modem inputs read inactive while pins serve as general I/O
         modem_in_d = 3'h7;
      end
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         gpio_in_q   <= '0;
         modem_in_q  <= 3'h7;
         modem_act_q <= 1'b0;
      end else begin
         gpio_in_q   <= gpio_in_d;
         modem_in_q  <= modem_in_d;
         modem_act_q <= modem_act_d;
      end
   end

   for (genvar i = 0; i < PROG_PINS; i++) begin : g_prog
      hpfs_pin_cell u_pin (
         .clk       (CLK),
         .nrst      (NRST),
         .drive_en  (pin_drive[i]),
         .drive_val (pin_val[i]),
         .pin_o     (PROG_PIN_O[i]),
         .pin_oe_n  (PROG_PIN_OE_N[i])
      );
   end

   assign GPIO_IN           = gpio_in_q;
   assign MODEM_PINS_ACTIVE = modem_act_q;
   assign MODEM_DSR_N       = modem_in_q[0];
   assign MODEM_CD_N        = modem_in_q[1];
   assign MODEM_RI_N        = modem_in_q[2];

endmodule : hpfs_top

// file: testbench/hpfs_host_model.sv
// Host side model: board strap and wiring of the shared lines.
// Assumes the bench steers it with plain levels.
`timescale 1ns/1ns
module hpfs_host_model (
   // Clock
   input  wire logic CLK,
   // Host requests
   input  wire logic want_i2c,
   input  wire logic host_sda_low,
   // Device pins
   input  wire logic SO_O,
   input  wire logic SO_OE_N,
   input  wire logic SDA_OE_N,
   // Wire levels
   output logic      BUS_SEL_I2C,
   output logic      SDA_I,
   output logic      so_line
);
   logic so_last = 1'b0;
   assign BUS_SEL_I2C = want_i2c;
   // Pull-up in two-wire mode, tied low otherwise
   assign SDA_I = want_i2c && !(host_sda_low || !SDA_OE_N);
   // Released line must not keep the last value
   // Sampled mid-cycle so a release edge never races the last value
   always @(negedge CLK) if (!SO_OE_N) so_last <= SO_O;
   assign so_line = SO_OE_N ? !so_last : SO_O;
endmodule : hpfs_host_model

// file: testbench/hpfs_top_chk.sv
// Checker for the pin function select block, top ports only.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module hpfs_top_chk #(
   parameter int PROG_PINS = 4
) (
   // Clock, reset, straps
   input wire logic                    CLK,
   input wire logic                    NRST,
   input wire logic                    BUS_SEL_I2C,
   input wire logic                    SELECT_OR_ADDR_STRAP_LOW,
   input wire logic                    SERIAL_IN_OR_ADDR_STRAP_HIGH,
   // Pins
   input wire logic                    SO_O,
   input wire logic                    SO_OE_N,
   input wire logic                    SDA_O,
   input wire logic                    SDA_OE_N,
   input wire logic                    IRQ_N_OE_N,
   input wire logic                    RTS_N,
   input wire logic [PROG_PINS-1:0]    PROG_PIN_O,
   input wire logic [PROG_PINS-1:0]    PROG_PIN_OE_N,
   // Core side
   input wire hpfs_pkg::hpfs_strap_t   STRAP,
   input wire logic                    STRAP_VALID,
   input wire logic                    CORE_SO_DATA,
   input wire logic                    CORE_SO_EN,
   input wire logic                    CORE_SDA_PULL_LOW,
   input wire logic [7:0]              INTERRUPT_ENABLE_REG,
   input wire logic [7:0]              MODEM_CONTROL_REG,
   input wire logic [7:0]              ENHANCED_FEATURE_REG,
   input wire logic [7:0]              IO_CONTROL_REG,
   input wire hpfs_pkg::hpfs_irq_src_t IRQ_SRC,
   input wire logic                    IRQ_PENDING,
   input wire logic                    AUTO_RTS_READY
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);
   wire logic spi_run = STRAP_VALID && !STRAP.is_i2c;
   wire logic irq_hit = |(IRQ_SRC & INTERRUPT_ENABLE_REG[4:0]);

   a_strap_take: assert property (!STRAP_VALID |=> STRAP_VALID && STRAP ==
      ($past(BUS_SEL_I2C) ? {1'b1, $past(SERIAL_IN_OR_ADDR_STRAP_HIGH), $past(SELECT_OR_ADDR_STRAP_LOW)} : 3'h0))
      else $error("strap capture wrong");
   a_so_release: assert property (STRAP_VALID && (STRAP.is_i2c || SELECT_OR_ADDR_STRAP_LOW) |=> SO_OE_N)
      else $error("serial out driven while deselected");
   a_so_drive: assert property (spi_run && !SELECT_OR_ADDR_STRAP_LOW && CORE_SO_EN
      |=> !SO_OE_N && SO_O == $past(CORE_SO_DATA)) else $error("serial out not driven");
   a_sda_pull: assert property (STRAP_VALID && STRAP.is_i2c |=> !SDA_O && SDA_OE_N == !$past(CORE_SDA_PULL_LOW))
      else $error("data pin drive wrong");
   a_irq_raise: assert property (STRAP_VALID && irq_hit |=> IRQ_PENDING ##1 !IRQ_N_OE_N)
      else $error("interrupt not raised");
   a_irq_quiet: assert property (STRAP_VALID && !irq_hit |=> !IRQ_PENDING ##1 IRQ_N_OE_N)
      else $error("interrupt without enabled source");
   a_rts_manual: assert property (STRAP_VALID && !ENHANCED_FEATURE_REG[6]
      |=> RTS_N == !$past(MODEM_CONTROL_REG[1])) else $error("request to send wrong");
   a_rts_auto: assert property (STRAP_VALID && ENHANCED_FEATURE_REG[6]
      |=> RTS_N == !$past(AUTO_RTS_READY)) else $error("auto request to send wrong");
   a_rts_reset: assert property (disable iff (1'b0) !NRST |=> RTS_N)
      else $error("request to send low after reset");
   a_dtr_drive: assert property (STRAP_VALID && IO_CONTROL_REG[1]
      |=> !PROG_PIN_OE_N[1] && PROG_PIN_O[1] == !$past(MODEM_CONTROL_REG[0])) else $error("terminal ready wrong");
endmodule : hpfs_top_chk

// file: testbench/hpfs_top_bench.sv
// Testbench for the pin function select block with a host model.
// Assumes the design sources and package are compiled first.
`timescale 1ns/1ns
module hpfs_top_bench;
   logic CLK, NRST, SELECT_OR_ADDR_STRAP_LOW, SERIAL_IN_OR_ADDR_STRAP_HIGH, BUS_SEL_I2C, SDA_I;
   logic SO_O, SO_OE_N, SDA_O, SDA_OE_N, IRQ_N_O, IRQ_N_OE_N, RTS_N, STRAP_VALID, SPI_CS_N, SPI_DATA_IN;
   logic CORE_SO_DATA, CORE_SO_EN, CORE_SDA_PULL_LOW, CORE_SDA_IN, IRQ_PENDING, AUTO_RTS_READY, AUTO_RTS_EN;
   logic MODEM_PINS_ACTIVE, MODEM_DSR_N, MODEM_CD_N, MODEM_RI_N, want_i2c, host_sda_low, so_line;
   logic [3:0] PROG_PIN_I, PROG_PIN_O, PROG_PIN_OE_N, GPIO_OUT, GPIO_DIR_OUT, GPIO_IN;
   logic [7:0] INTERRUPT_ENABLE_REG, MODEM_CONTROL_REG, ENHANCED_FEATURE_REG, IO_CONTROL_REG;
   hpfs_pkg::hpfs_strap_t   STRAP;
   hpfs_pkg::hpfs_irq_src_t IRQ_SRC;
   int num_errors = 0;
   int n_tests = 0;

   hpfs_top i_hpfs_top (.*);
   hpfs_host_model i_hpfs_host_model (.*);

   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end

   task automatic chk(logic [15:0] seen, logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wt(int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask : wt

   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : test_done

   // Reset for 7 cycles with the straps set, then release
   task automatic boot(logic i2c, logic lo, logic hi);
      @(posedge CLK);
      NRST <= 1'b0;
      want_i2c <= i2c;
      SELECT_OR_ADDR_STRAP_LOW <= lo;
      SERIAL_IN_OR_ADDR_STRAP_HIGH <= hi;
      wt(6);
      chk({RTS_N, SO_OE_N, SDA_OE_N, IRQ_N_OE_N, STRAP_VALID}, 5'h1e);
      @(posedge CLK);
      NRST <= 1'b1;
      wt(2);
      chk({STRAP_VALID, STRAP}, i2c ? {2'b11, hi, lo} : 4'h8);
   endtask : boot

   initial begin
      {NRST, want_i2c, host_sda_low, SERIAL_IN_OR_ADDR_STRAP_HIGH, CORE_SO_DATA, CORE_SO_EN} = '0;
      {CORE_SDA_PULL_LOW, AUTO_RTS_READY, SELECT_OR_ADDR_STRAP_LOW} = 3'h1;
      {INTERRUPT_ENABLE_REG, MODEM_CONTROL_REG, ENHANCED_FEATURE_REG, IO_CONTROL_REG} = '0;
      {IRQ_SRC, GPIO_OUT, GPIO_DIR_OUT, PROG_PIN_I} = '0;
      // ****************************************
      // Four-wire: chip select gates serial out
      // ****************************************
      boot(1'b0, 1'b1, 1'b1);
      for (int i = 0; i < 4; i++) begin
         @(posedge CLK);
         SELECT_OR_ADDR_STRAP_LOW <= i[1];
         SERIAL_IN_OR_ADDR_STRAP_HIGH <= ~i[0];
         CORE_SO_EN <= 1'b1;
         CORE_SO_DATA <= i[0];
         CORE_SDA_PULL_LOW <= 1'b1;
         wt(1);
         chk({SO_OE_N, SO_O & !SO_OE_N, so_line}, {i[1], i[0] & !i[1], i[0] & !i[1]});
         chk({SPI_CS_N, SPI_DATA_IN, SDA_OE_N, CORE_SDA_IN}, {i[1], ~i[0], 2'b11});
      end
      $display("test four_wire done");
      // ****************************************
      // Two-wire: address straps, data pin
      // ****************************************
      boot(1'b1, 1'b0, 1'b1);
      for (int i = 0; i < 3; i++) begin
         @(posedge CLK);
         CORE_SDA_PULL_LOW <= (i == 1);
         host_sda_low <= (i == 2);
         SELECT_OR_ADDR_STRAP_LOW <= 1'b0;
         SERIAL_IN_OR_ADDR_STRAP_HIGH <= 1'b0;
         wt(2);
         chk({SDA_OE_N, SDA_O, CORE_SDA_IN, SO_OE_N, STRAP}, {i != 1, 1'b0, i == 0, 4'he});
      end
      $display("test two_wire done");
      // ****************************************
      // Interrupt sources, masked then enabled
      // ****************************************
      for (int i = 0; i < 5; i++) begin
         @(posedge CLK);
         IRQ_SRC <= 5'h1 << i;
         INTERRUPT_ENABLE_REG <= 8'hff ^ (8'h1 << i);
         wt(2);
         chk({IRQ_PENDING, IRQ_N_OE_N}, 2'b01);
         @(posedge CLK);
         INTERRUPT_ENABLE_REG <= 8'h1 << i;
         wt(1);
         chk(IRQ_PENDING, 1'b1);
         wt(1);
         chk({IRQ_N_OE_N, IRQ_N_O}, 2'b00);
      end
      $display("test interrupt done");
      // ****************************************
      // Request to send, manual and automatic
      // ****************************************
      for (int i = 0; i < 4; i++) begin
         @(posedge CLK);
         ENHANCED_FEATURE_REG <= {1'b0, i[1], 6'h0};
         MODEM_CONTROL_REG <= {6'h0, i[0], 1'b0};
         AUTO_RTS_READY <= ~i[0];
         wt(1);
         chk({RTS_N, AUTO_RTS_EN}, {i[1] ? i[0] : ~i[0], i[1]});
      end
      $display("test request_to_send done");
      // ****************************************
      // Programmable pins, general then modem
      // ****************************************
      @(posedge CLK);
      GPIO_OUT <= 4'ha;
      GPIO_DIR_OUT <= 4'h6;
      PROG_PIN_I <= 4'h5;
      MODEM_CONTROL_REG <= 8'h1;
      wt(2);
      chk({MODEM_PINS_ACTIVE, PROG_PIN_OE_N, PROG_PIN_O & GPIO_DIR_OUT, GPIO_IN}, 13'h0925);
      @(posedge CLK);
      IO_CONTROL_REG <= 8'h2;
      PROG_PIN_I <= 4'h4;
      wt(2);
      chk({MODEM_PINS_ACTIVE, PROG_PIN_OE_N, PROG_PIN_O[1], MODEM_DSR_N, MODEM_CD_N, MODEM_RI_N, GPIO_IN},
          13'h1d20);
      $display("test prog_pins done");
      test_done();
   end

   // Whole run takes well under 300 cycles
   initial begin
      repeat (3000) @(posedge CLK);
      num_errors++;
      test_done();
   end
endmodule : hpfs_top_bench

bind hpfs_top hpfs_top_chk #(.PROG_PINS(PROG_PINS)) i_hpfs_top_chk (.*);
